// file: logic/vls_defines.svh
`ifndef VLS_DEFINES_SVH
`define VLS_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define VLS_CLK_MHZ 200
`define VLS_TERM_PULSE_MS 100
`define VLS_UPDATE_CYCLES 8'h10
`define VLS_SYNC_SETTLE 3'h4

// ----------------------------------------
// Serial slave address
// ----------------------------------------
`define VLS_ADDR_FIXED 4'h9
`define VLS_DEV_LSB 8
`define VLS_DEV_MSB 14

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define VLS_REG_SOURCE 8'h00
`define VLS_REG_PULSE 8'h04
`define VLS_REG_RX 8'h08
`define VLS_REG_TX 8'h0C
`define VLS_REG_MODE 8'h10
`define VLS_REG_STATUS 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VLS_RX_GOFF 0
`define VLS_RX_BOOST_LSB 8
`define VLS_TX_OTERM 0
`define VLS_TX_OCUR 1
`define VLS_OUTPUT_PREEMPH_LEVEL_LSB 2
`define VLS_MODE_DRV 0
`define VLS_ST_SERIAL 0
`define VLS_ST_PULSE 1
`define VLS_ST_BUSY 2
`define VLS_ST_SRC_LSB 8
`define VLS_ST_ADDR_LSB 16

// ----------------------------------------
// Pin vector positions
// ----------------------------------------
`define VLS_PIN_W 11
`define VLS_PIN_SRC 0
`define VLS_PIN_BOOST 2
`define VLS_PIN_OTERM 3
`define VLS_PIN_DRV 4
`define VLS_PIN_OCUR 5
`define VLS_PIN_PE 6
`define VLS_PIN_STRAP 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VLS_RST_SRC 2'h0
`define VLS_RST_PULSE 16'h0000
`define VLS_RST_GOFF 1'h0
`define VLS_RST_BOOST 8'h00
`define VLS_RST_PE 2'h0
`define VLS_RST_DRV 1'h1
`define VLS_RST_APP 32'h0000_0000

`endif

// file: logic/vls_pkg.sv
package vls_pkg;

	// Applied configuration bundle, 32 bits wide
	typedef struct packed {
		logic [1:0] src;
		logic [15:0] pulse_en;
		logic goff;
		logic [7:0] boost;
		logic oterm;
		logic ocur;
		logic [1:0] pe;
		logic drv;
	} vls_cfg_t;

	// Strap capture after reset release
	typedef enum logic [1:0] {
		VLS_ST_WAIT = 2'b00,
		VLS_ST_LOAD = 2'b01,
		VLS_ST_RUN = 2'b10
	} vls_strap_t;

endpackage : vls_pkg

// file: logic/vls_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vls_cfg_if
	import vls_pkg::*;
(
	input wire logic clock, // Core clock
	input wire logic rst_b // Async reset, active low
);
	vls_cfg_t req_cfg;
	vls_cfg_t app_cfg;
	logic ce;
	logic pulse_active;
	logic window_busy;

	modport core(output req_cfg, output ce, input app_cfg,
		input pulse_active, input window_busy);
	modport timer(input clock, input rst_b, input ce, input req_cfg,
		output app_cfg, output pulse_active, output window_busy);
endinterface : vls_cfg_if
`default_nettype wire

// file: logic/vls_update_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "vls_defines.svh"
module vls_update_timer
	import vls_pkg::*;
#(
	parameter int PULSE_CYCLES = `VLS_TERM_PULSE_MS * 1000 * `VLS_CLK_MHZ
) (
	vls_cfg_if.timer cfg // Requested and applied settings
);
	localparam logic [24:0] PULSE_LOAD = 25'(PULSE_CYCLES);

	vls_cfg_t app_ff, nxt_app;
	logic busy_ff, nxt_busy;
	logic [7:0] win_cnt_ff, nxt_win_cnt;
	logic [24:0] pulse_cnt_ff, nxt_pulse_cnt;

	// ----------------------------------------
	// Update window and termination pulse
	// ----------------------------------------
	// Writes during a window only change the request; the window is
	// not restarted, so a chatty master cannot stall the update forever
	always_comb begin
		nxt_app = app_ff;
		nxt_busy = busy_ff;
		nxt_win_cnt = win_cnt_ff;
		nxt_pulse_cnt = pulse_cnt_ff;
		if (cfg.ce) begin
			if (pulse_cnt_ff != 25'h0) begin
				nxt_pulse_cnt = pulse_cnt_ff - 25'h1;
			end
			if (busy_ff) begin
				if (win_cnt_ff == 8'h01) begin
					nxt_busy = 1'b0;
					nxt_app = cfg.req_cfg;
				end else begin
					nxt_win_cnt = win_cnt_ff - 8'h01;
				end
			end else if (cfg.req_cfg != app_ff) begin
				nxt_app = cfg.req_cfg;
				nxt_busy = 1'b1;
				nxt_win_cnt = `VLS_UPDATE_CYCLES;
			end
			// A source switch (re)starts the disconnect pulse
			if (nxt_app.src != app_ff.src) begin
				nxt_pulse_cnt = PULSE_LOAD;
			end
		end
	end

	// Registers only
	always_ff @(posedge cfg.clock or negedge cfg.rst_b) begin
		if (!cfg.rst_b) begin
			app_ff <= `VLS_RST_APP;
			busy_ff <= 1'b0;
			win_cnt_ff <= 8'h00;
			pulse_cnt_ff <= 25'h0;
		end else begin
			app_ff <= nxt_app;
			busy_ff <= nxt_busy;
			win_cnt_ff <= nxt_win_cnt;
			pulse_cnt_ff <= nxt_pulse_cnt;
		end
	end

	assign cfg.app_cfg = app_ff;
	assign cfg.pulse_active = (pulse_cnt_ff != 25'h0);
	assign cfg.window_busy = busy_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_window_hold: assert property (@(posedge cfg.clock)
		disable iff (!cfg.rst_b)
		busy_ff && win_cnt_ff != 8'h01 |=> $stable(app_ff))
		else $error("applied settings moved inside window");
	a_window_end: assert property (@(posedge cfg.clock)
		disable iff (!cfg.rst_b)
		busy_ff && win_cnt_ff == 8'h01 && cfg.ce
		|=> app_ff == $past(cfg.req_cfg) && !busy_ff)
		else $error("window end did not take last request");
	a_pulse_start: assert property (@(posedge cfg.clock)
		disable iff (!cfg.rst_b)
		app_ff.src != $past(app_ff.src) |-> pulse_cnt_ff == PULSE_LOAD)
		else $error("source switch did not start pulse");
	c_window_rewrite: cover property (@(posedge cfg.clock)
		disable iff (!cfg.rst_b)
		busy_ff && cfg.req_cfg != $past(cfg.req_cfg));
endmodule : vls_update_timer
`default_nettype wire

// file: logic/vls_ctrl.sv
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vls_defines.svh"
module vls_ctrl
	import vls_pkg::*;
#(
	parameter int PULSE_CYCLES = `VLS_TERM_PULSE_MS * 1000 * `VLS_CLK_MHZ
) (
	input wire logic clock, // 200 MHz core clock
	input wire logic rst_b, // Async reset, active low
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Write
	input wire logic [14:0] wb_adr_i, // Device field and byte offset
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic [1:0] pin_source_select, // Source pins
	input wire logic pin_boost_select, // Boost pin, 1 = 12 dB
	input wire logic pin_output_term_enable, // Output termination pin
	input wire logic pin_output_drive_enable, // Output enable pin
	input wire logic pin_output_current_select, // Current pin
	input wire logic [1:0] pin_preemph_level, // Pre-emphasis pins
	input wire logic slave_addr_strap_bit0, // Address strap LSB
	input wire logic slave_addr_strap_bit1, // Address strap
	input wire logic slave_addr_strap_bit2, // Address strap MSB
	output logic [3:0] link_select, // One-hot high speed source
	output logic [3:0] aux_select, // One-hot auxiliary source
	output logic [15:0] input_term_connect, // 1 = termination on
	output logic [7:0] input_boost_select, // 1 = 12 dB, 0 = 6 dB
	output logic output_term_enable, // Internal output termination
	output logic output_current_select, // Output current level
	output logic [1:0] output_preemph_level, // Pre-emphasis level
	output logic output_drive_enable, // 1 = outputs driven
	output logic hs_output_tristate, // 1 = outputs tristate
	output logic serial_mode // Serial control has taken over
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [3:0] vls_onehot(input logic [1:0] sel);
		vls_onehot = 4'h1 << sel;
	endfunction : vls_onehot

	function automatic logic [31:0] vls_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		vls_merge = res;
	endfunction : vls_merge

	// ----------------------------------------
	// Pin synchroniser and filter
	// ----------------------------------------
	logic [`VLS_PIN_W-1:0] pin_raw;
	logic [`VLS_PIN_W-1:0] s1_ff, s2_ff, s3_ff, pin_ok_ff;
	logic [`VLS_PIN_W-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_pin_ok;

	assign pin_raw = {slave_addr_strap_bit2, slave_addr_strap_bit1,
		slave_addr_strap_bit0, pin_preemph_level, pin_output_current_select,
		pin_output_drive_enable, pin_output_term_enable, pin_boost_select,
		pin_source_select};

	// A bit is accepted only once stages two and three agree
	always_comb begin
		nxt_s1 = s1_ff;
		nxt_s2 = s2_ff;
		nxt_s3 = s3_ff;
		nxt_pin_ok = pin_ok_ff;
		if (ce) begin
			nxt_s1 = pin_raw;
			nxt_s2 = s1_ff;
			nxt_s3 = s2_ff;
			for (int i = 0; i < `VLS_PIN_W; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					nxt_pin_ok[i] = s3_ff[i];
				end
			end
		end
	end

	// Registers only
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			pin_ok_ff <= '0;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
			pin_ok_ff <= nxt_pin_ok;
		end
	end

	logic [6:0] slave_addr;
	assign slave_addr = {`VLS_ADDR_FIXED,
		pin_ok_ff[`VLS_PIN_STRAP +: 3]};

	// ----------------------------------------
	// Bus slave and configuration registers
	// ----------------------------------------
	logic ack_ff, nxt_ack;
	logic [31:0] dat_ff, nxt_dat;
	logic serial_ff, nxt_serial;
	logic [1:0] src_ff, nxt_src;
	logic [15:0] pulse_ff, nxt_pulse;
	logic goff_ff, nxt_goff;
	logic [7:0] boost_ff, nxt_boost;
	logic oterm_ff, nxt_oterm;
	logic ocur_ff, nxt_ocur;
	logic [1:0] pe_ff, nxt_pe;
	logic drv_ff, nxt_drv;
	vls_strap_t strap_ff, nxt_strap;
	logic [2:0] settle_ff, nxt_settle;
	logic req, dev_hit;
	logic [7:0] off;
	logic [31:0] v_src, v_pulse, v_rx, v_tx, v_mode, v_stat, rd;
	vls_cfg_t app;
	logic pulse_active, window_busy;

	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign dev_hit = (wb_adr_i[`VLS_DEV_MSB:`VLS_DEV_LSB] == slave_addr);
	assign off = wb_adr_i[7:0];

	// Word views of each register
	assign v_src = {30'h0, src_ff};
	assign v_pulse = {16'h0, pulse_ff};
	assign v_rx = {16'h0, boost_ff, 7'h0, goff_ff};
	assign v_tx = {28'h0, pe_ff, ocur_ff, oterm_ff};
	assign v_mode = {31'h0, drv_ff};
	assign v_stat = {9'h0, slave_addr, 6'h0, app.src, 5'h0, window_busy,
		pulse_active, serial_ff};

	// Read mux; unmapped offsets and foreign addresses read zero
	always_comb begin
		rd = 32'h0;
		case (off)
			`VLS_REG_SOURCE: rd = v_src;
			`VLS_REG_PULSE: rd = v_pulse;
			`VLS_REG_RX: rd = v_rx;
			`VLS_REG_TX: rd = v_tx;
			`VLS_REG_MODE: rd = v_mode;
			`VLS_REG_STATUS: rd = v_stat;
			default: rd = 32'h0;
		endcase
		if (!dev_hit) begin
			rd = 32'h0;
		end
	end

	// Bus answers, writes, serial takeover and strap capture
	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		nxt_ack = ack_ff;
		nxt_dat = dat_ff;
		nxt_serial = serial_ff;
		nxt_src = src_ff;
		nxt_pulse = pulse_ff;
		nxt_goff = goff_ff;
		nxt_boost = boost_ff;
		nxt_oterm = oterm_ff;
		nxt_ocur = ocur_ff;
		nxt_pe = pe_ff;
		nxt_drv = drv_ff;
		nxt_strap = strap_ff;
		nxt_settle = settle_ff;
		if (ce) begin
			nxt_ack = req;
			if (req) begin
				nxt_dat = rd;
			end
			// Any access to this device, read or write, is sticky
			if (req && dev_hit) begin
				nxt_serial = 1'b1;
			end
			if (req && dev_hit && wb_we_i) begin
				case (off)
					`VLS_REG_SOURCE: begin
						m = vls_merge(v_src, wb_dat_i, wb_sel_i);
						nxt_src = m[1:0];
					end
					`VLS_REG_PULSE: begin
						m = vls_merge(v_pulse, wb_dat_i, wb_sel_i);
						nxt_pulse = m[15:0];
					end
					`VLS_REG_RX: begin
						m = vls_merge(v_rx, wb_dat_i, wb_sel_i);
						nxt_goff = m[`VLS_RX_GOFF];
						nxt_boost = m[`VLS_RX_BOOST_LSB +: 8];
					end
					`VLS_REG_TX: begin
						m = vls_merge(v_tx, wb_dat_i, wb_sel_i);
						nxt_oterm = m[`VLS_TX_OTERM];
						nxt_ocur = m[`VLS_TX_OCUR];
						nxt_pe = m[`VLS_OUTPUT_PREEMPH_LEVEL_LSB +: 2];
					end
					`VLS_REG_MODE: begin
						m = vls_merge(v_mode, wb_dat_i, wb_sel_i);
						nxt_drv = m[`VLS_MODE_DRV];
					end
					default: m = 32'h0;
				endcase
			end
			// Pins are only trusted once the filter has settled
			case (strap_ff)
				VLS_ST_WAIT: begin
					nxt_settle = settle_ff + 3'h1;
					if (settle_ff == `VLS_SYNC_SETTLE) begin
						nxt_strap = VLS_ST_LOAD;
					end
				end
				VLS_ST_LOAD: begin
					nxt_oterm = pin_ok_ff[`VLS_PIN_OTERM];
					nxt_ocur = pin_ok_ff[`VLS_PIN_OCUR];
					nxt_strap = VLS_ST_RUN;
				end
				VLS_ST_RUN: nxt_strap = VLS_ST_RUN;
				default: nxt_strap = VLS_ST_WAIT;
			endcase
		end
	end

	// Registers only; oterm and ocur take their defaults from the straps, the rest are constant
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0;
			serial_ff <= 1'b0;
			src_ff <= `VLS_RST_SRC;
			pulse_ff <= `VLS_RST_PULSE;
			goff_ff <= `VLS_RST_GOFF;
			boost_ff <= `VLS_RST_BOOST;
			oterm_ff <= 1'b0;
			ocur_ff <= 1'b0;
			pe_ff <= `VLS_RST_PE;
			drv_ff <= `VLS_RST_DRV;
			strap_ff <= VLS_ST_WAIT;
			settle_ff <= 3'h0;
		end else begin
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
			serial_ff <= nxt_serial;
			src_ff <= nxt_src;
			pulse_ff <= nxt_pulse;
			goff_ff <= nxt_goff;
			boost_ff <= nxt_boost;
			oterm_ff <= nxt_oterm;
			ocur_ff <= nxt_ocur;
			pe_ff <= nxt_pe;
			drv_ff <= nxt_drv;
			strap_ff <= nxt_strap;
			settle_ff <= nxt_settle;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign serial_mode = serial_ff;

	// ----------------------------------------
	// Requested settings and update timer
	// ----------------------------------------
	vls_cfg_t req_cfg;

	// Pin control cannot touch input terminations at all
	always_comb begin
		if (serial_ff) begin
			req_cfg = '{src: src_ff, pulse_en: pulse_ff, goff: goff_ff,
				boost: boost_ff, oterm: oterm_ff, ocur: ocur_ff,
				pe: pe_ff, drv: drv_ff};
		end else begin
			req_cfg.src = pin_ok_ff[`VLS_PIN_SRC +: 2];
			req_cfg.pulse_en = 16'h0000;
			req_cfg.goff = 1'b0;
			req_cfg.boost = {8{pin_ok_ff[`VLS_PIN_BOOST]}};
			req_cfg.oterm = pin_ok_ff[`VLS_PIN_OTERM];
			req_cfg.ocur = pin_ok_ff[`VLS_PIN_OCUR];
			req_cfg.pe = pin_ok_ff[`VLS_PIN_PE +: 2];
			req_cfg.drv = pin_ok_ff[`VLS_PIN_DRV];
		end
	end

	vls_cfg_if u_cfg_if (
		.clock(clock),
		.rst_b(rst_b)
	);
	assign u_cfg_if.req_cfg = req_cfg;
	assign u_cfg_if.ce = ce;
	assign app = u_cfg_if.app_cfg;
	assign pulse_active = u_cfg_if.pulse_active;
	assign window_busy = u_cfg_if.window_busy;

	vls_update_timer #(
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_timer (
		.cfg(u_cfg_if)
	);

	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	logic [15:0] term_ff, nxt_term;
	logic [3:0] link_ff, nxt_link;

	// Gated terminations and one-hot routing, registered for clean pins
	always_comb begin
		nxt_term = term_ff;
		nxt_link = link_ff;
		if (ce) begin
			nxt_term = ~({16{app.goff}} |
				(pulse_active ? app.pulse_en : 16'h0000));
			nxt_link = vls_onehot(app.src);
		end
	end

	// Registers only; all terminations on out of reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			term_ff <= 16'hFFFF;
			link_ff <= 4'h1;
		end else begin
			term_ff <= nxt_term;
			link_ff <= nxt_link;
		end
	end

	assign input_term_connect = term_ff;
	assign link_select = link_ff;
	assign aux_select = link_ff;
	assign input_boost_select = app.boost;
	assign output_term_enable = app.oterm;
	assign output_current_select = app.ocur;
	assign output_preemph_level = app.pe;
	assign output_drive_enable = app.drv;
	assign hs_output_tristate = !app.drv;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_serial_sticky: assert property (serial_ff |=> serial_ff)
		else $error("serial mode dropped without reset");
	a_pins_ignored: assert property (serial_ff
		|-> req_cfg.src == src_ff && req_cfg.drv == drv_ff)
		else $error("pins steer settings in serial mode");
	a_addr_filter: assert property (req && !dev_hit
		&& !serial_ff |=> !serial_ff)
		else $error("foreign address took serial control");
	a_addr_fixed: assert property (req
		&& wb_adr_i[14:11] != 4'h9 |-> !dev_hit)
		else $error("fixed address bits not checked");
	a_parallel_terms: assert property (!serial_ff && ce
		|=> ##[1:40] input_term_connect == 16'hFFFF)
		else $error("input termination switched under pins");
	a_global_off: assert property (ce && app.goff
		|=> input_term_connect == 16'h0000)
		else $error("global off left a termination on");
	a_boost_all: assert property (!serial_ff
		|-> req_cfg.boost == {8{pin_ok_ff[`VLS_PIN_BOOST]}})
		else $error("boost pin not applied to all channels");
	a_onehot_route: assert property ($onehot(link_select)
		&& aux_select == link_select)
		else $error("routing not one-hot or aux mismatch");
	a_strap_load: assert property (strap_ff == VLS_ST_LOAD
		&& ce |=> oterm_ff == $past(pin_ok_ff[`VLS_PIN_OTERM])
		&& ocur_ff == $past(pin_ok_ff[`VLS_PIN_OCUR]))
		else $error("straps not loaded after reset");
	// A frozen clock enable legally stretches ack, so only count live cycles
	a_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o)
		else $error("ack held for two cycles");
	a_ce_freeze: assert property (!ce |=> $stable(input_term_connect))
		else $error("terminations moved with clock enable low");

	c_takeover: cover property (!serial_ff ##1 serial_ff);
	c_pulse: cover property (pulse_active && input_term_connect != 16'hFFFF
		&& !app.goff);
	c_tristate: cover property (serial_ff && hs_output_tristate);
endmodule : vls_ctrl
`default_nettype wire

// file: dv/vls_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vls_host_model (
	input wire logic clock, // Core clock
	input wire logic [31:0] wb_dat_o, // Read data from the block
	input wire logic wb_ack_o, // Acknowledge from the block
	output var logic wb_cyc_i, // Bus cycle
	output var logic wb_stb_i, // Bus strobe
	output var logic wb_we_i, // Write
	output var logic [14:0] wb_adr_i, // Device field and offset
	output var logic [3:0] wb_sel_i, // Byte enables
	output var logic [31:0] wb_dat_i, // Write data
	output var logic [10:0] pins // Parallel control pins and straps
);
	// ----------------------------------------
	// Idle bus and pins at time zero
	// ----------------------------------------
	initial begin
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 15'h0000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		pins = 11'h000;
	end

	// One classic cycle; the request holds until ack is sampled high.
	// Released data and address lines flip so a stale value is never mistaken for data.
	task automatic xfer(input logic we, input logic [6:0] dev,
		input logic [7:0] off, input logic [31:0] d,
		output logic [31:0] q);
		q = 'x;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {dev, off};
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		// No cycle limit here: only the bench watchdog ends a hung wait
		do begin
			@(posedge clock);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_dat_i <= ~d;
		wb_adr_i <= ~{dev, off};
	endtask : xfer

	// Board pins change only just after an edge
	task automatic set_pins(input logic [10:0] v);
		@(posedge clock);
		pins <= v;
	endtask : set_pins
endmodule : vls_host_model
`default_nettype wire

// file: dv/test_video_link_switch_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_video_link_switch_control;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic wb_cyc, wb_stb, wb_we, wb_ack, oterm, ocur, drv, tri_o, ser;
	logic [14:0] wb_adr;
	logic [3:0] wb_sel, link, aux;
	logic [31:0] wb_wdat, wb_rdat, rd;
	logic [10:0] pins;
	logic [15:0] term;
	logic [7:0] boost;
	logic [1:0] pe;
	logic [6:0] dev;
	int failures = 0;
	int tests_run = 0;

	// ----------------------------------------
	// Clock, address and instances
	// ----------------------------------------
	// 200 MHz core clock
	always #2.5 clock = ~clock;
	// Expected slave address: fixed upper nibble, then straps
	assign dev = {4'h9, pins[10:8]};

	// Short pulse keeps the termination test fast
	vls_ctrl #(.PULSE_CYCLES(50)) vls_ctrl_inst (.clock(clock),
		.rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.pin_source_select(pins[1:0]), .pin_boost_select(pins[2]),
		.pin_output_term_enable(pins[3]),
		.pin_output_drive_enable(pins[4]),
		.pin_output_current_select(pins[5]),
		.pin_preemph_level(pins[7:6]), .slave_addr_strap_bit0(pins[8]),
		.slave_addr_strap_bit1(pins[9]), .slave_addr_strap_bit2(pins[10]),
		.link_select(link), .aux_select(aux), .input_term_connect(term),
		.input_boost_select(boost), .output_term_enable(oterm),
		.output_current_select(ocur), .output_preemph_level(pe),
		.output_drive_enable(drv), .hs_output_tristate(tri_o),
		.serial_mode(ser));
	vls_host_model vls_host_model_inst (.clock(clock), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .pins(pins));

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		vls_host_model_inst.xfer(1'b1, dev, off, d, rd);
	endtask : wr
	task automatic rdr(input logic [7:0] off);
		vls_host_model_inst.xfer(1'b0, dev, off, 32'h0000_0000, rd);
	endtask : rdr
	task automatic nap(input int n);
		repeat (n) @(posedge clock);
	endtask : nap
	// Long settle covers the pin filter and one update window
	task automatic do_reset;
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		nap(40);
	endtask : do_reset
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_pins;
		vls_host_model_inst.set_pins(11'h5FE);
		do_reset();
		chk(32'({link, aux}), 32'h44);
		chk(32'(boost), 32'hFF);
		chk(32'(term), 32'hFFFF);
		chk(32'({oterm, ocur, pe}), 32'hF);
		chk(32'({drv, tri_o, ser}), 32'h4);
		vls_host_model_inst.set_pins(11'h5ED);
		nap(40);
		chk(32'(link), 32'h2);
		chk(32'({drv, tri_o}), 32'h1);
		chk(32'(term), 32'hFFFF);
		do_reset();
	endtask : t_pins
	// Foreign address is ignored; own address takes over
	task automatic t_serial;
		vls_host_model_inst.xfer(1'b0, dev ^ 7'h01, 8'h14, 32'h0, rd);
		chk(rd, 32'h0);
		chk(32'(ser), 32'h0);
		rdr(8'h14);
		chk(32'(rd[22:16]), 32'(dev));
		nap(2);
		chk(32'(ser), 32'h1);
		rdr(8'h18);
		chk(rd, 32'h0);
		vls_host_model_inst.set_pins(11'h5EF);
		nap(40);
		chk(32'(link), 32'h1);
		chk(32'({drv, tri_o}), 32'h2);
		chk(32'({oterm, ocur}), 32'h3);
	endtask : t_serial
	task automatic t_pulse;
		wr(8'h04, 32'h0000_00F0);
		nap(20);
		wr(8'h00, 32'h0000_0003);
		nap(4);
		chk(32'(link), 32'h8);
		chk(32'(term), 32'hFF0F);
		rdr(8'h14);
		chk(rd & 32'h0000_03FF, 32'h307);
		nap(60);
		chk(32'(term), 32'hFFFF);
		rdr(8'h00);
		chk(rd, 32'h3);
	endtask : t_pulse
	task automatic t_rx;
		wr(8'h08, 32'h0000_A501);
		nap(20);
		chk(32'(term), 32'h0);
		chk(32'(boost), 32'hA5);
		wr(8'h08, 32'h0000_A500);
		nap(20);
		chk(32'(term), 32'hFFFF);
		rdr(8'h08);
		chk(rd, 32'h0000_A500);
	endtask : t_rx
	// Every pre-emphasis level, then internal termination at 20 mA
	task automatic t_tx;
		for (int i = 0; i < 4; i++) begin
			wr(8'h0C, 32'(i) << 2);
			nap(20);
			chk(32'({oterm, ocur, pe}), 32'(i));
		end
		wr(8'h0C, 32'h0000_0003);
		nap(20);
		chk(32'({oterm, ocur, pe}), 32'hC);
	endtask : t_tx
	task automatic t_mode;
		wr(8'h10, 32'h0);
		nap(20);
		chk(32'({drv, tri_o}), 32'h1);
		wr(8'h10, 32'h1);
		nap(20);
		chk(32'({drv, tri_o}), 32'h2);
	endtask : t_mode
	// Later writes land at window end and do not stretch it
	task automatic t_window;
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h2);
		wr(8'h00, 32'h3);
		chk(32'(link), 32'h2);
		nap(14);
		chk(32'(link), 32'h8);
	endtask : t_window
	// Clock enable low freezes the pulse counter and the routing
	task automatic t_freeze;
		wr(8'h00, 32'h0000_0000);
		@(posedge clock);
		ce <= 1'b0;
		nap(100);
		chk(32'({link, term}), 32'h1_FF0F);
		@(posedge clock);
		ce <= 1'b1;
		nap(60);
		chk(32'(term), 32'hFFFF);
	endtask : t_freeze
	task automatic t_reset2;
		vls_host_model_inst.set_pins(11'h512);
		do_reset();
		chk(32'(ser), 32'h0);
		chk(32'({oterm, ocur}), 32'h0);
		chk(32'(link), 32'h4);
		chk(32'(term), 32'hFFFF);
		rdr(8'h04);
		chk(rd, 32'h0);
	endtask : t_reset2

	// Main sequence
	initial begin
		t_pins();
		t_serial();
		t_pulse();
		t_rx();
		t_tx();
		t_mode();
		t_window();
		t_freeze();
		t_reset2();
		tally_and_finish();
	end
	// Watchdog: the whole run needs well under this many cycles
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		tally_and_finish();
	end
endmodule : test_video_link_switch_control
`default_nettype wire
